// ---- core/reset_source_sequencer.sv ----
`timescale 1ns/1ns
// Functional notes
// (R01) Internal reset clears all I/O registers; execution resumes at reset vector. Code clears only the power register; cause flags are kept.
// (R02) Port reset asserts asynchronously as soon as any source goes active.
// (R03) After all sources drop, reset is stretched by fuse-selected delay.
// (R04) Four causes: power-on, pin low, enabled watchdog expiry, enabled brown-out.
// (R05) Pin low beyond minimum width resets without clock; driver holds it.
// (R06) Pin release starts delay counter; processor released after it ends.
// (R07) Power-on detect asserts reset at once; its release starts the delay.
// (R08) Enabled brown-out asserts reset; supply recovery runs full delay.
// (R09) Brown-out ignores dips shorter than minimum low-voltage period.
// (R10) Watchdog time-out is one-cycle pulse; delay starts at its falling edge.
// (R11) Upper four bits of cause register read as zero.
// (R12) Watchdog flag bit 3: set by watchdog, cleared by power-on or write zero.
// (R13) Brown-out flag bit 2: set by brown-out, cleared by power-on or write zero.
// (R14) Pin flag bit 1: set by pin reset, cleared by power-on or write zero.
// (R15) Power-on flag bit 0: set by power-on, cleared only by writing zero.
// (R16) Software should read then clear cause flags early after start-up.
// (R17) Deep sleep with both clocks stopped disables non-wake input buffers.
// (R18) Comparator auto-off in deep sleep unless it uses internal reference.
// (R19) Reference powered only for brown-out, comparator or converter.
// (R20) Enabled watchdog and brown-out detector keep running in every sleep mode.
// (R21) Enabled converter stays on in sleep; re-enable forces extended conversion.
// (R22) Internal reset asserts asynchronously, releases synchronously after delay.
module reset_source_sequencer
	import reset_seq_pkg::*;
#(
	parameter int unsigned STARTUP_CYC0 = STARTUP_DEF_CYC[0],
	parameter int unsigned STARTUP_CYC1 = STARTUP_DEF_CYC[1],
	parameter int unsigned STARTUP_CYC2 = STARTUP_DEF_CYC[2],
	parameter int unsigned STARTUP_CYC3 = STARTUP_DEF_CYC[3],
	parameter int unsigned BO_MIN_CYC = BROWNOUT_MIN_CYC
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire reset_seq_pkg::reset_src_t src,
	input wire logic [reset_seq_pkg::STARTUP_SEL_W-1:0] clock_select_fuse,
	input wire logic sleep_active,
	input wire logic conversion_start,
	input wire reset_seq_pkg::bus_req_t bus,
	output logic [7:0] rdata,
	output logic internal_reset,
	output reset_seq_pkg::power_out_t pwr
);
	import reset_seq_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		seq_state_t state;
		logic [FLAG_W-1:0] flags;
		logic conv_en;
		logic cmp_en;
		logic cmp_ref;
		logic [MODE_W-1:0] mode;
		logic [7:0] rdata;
		power_out_t pwr;
	} seq_t;

	seq_t s_q, s_d;
	logic bo_active;
	logic wdog_pulse;
	logic pin_low;
	logic any_src;
	logic load;
	logic delay_done;
	logic reset_q;
	logic deep_sleep;
	logic cmp_on;

	// ------------------------------------------------------------
	// Sources
	// ------------------------------------------------------------
	brownout_filter #(
		.MIN_CYC(BO_MIN_CYC)
	) u_bo_filter (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.enable(src.brownout_enable_fuse),
		.below(src.supply_below_bot),
		.bo_active(bo_active)
	);

	assign wdog_pulse = src.wdog_timeout & src.wdog_enable; // see (R10)
	assign pin_low = ~src.reset_pin_n; // see (R05)
	// Exactly the four documented causes feed the combined source
	assign any_src = src.power_on_detect | pin_low | wdog_pulse | bo_active; // see (R04)

	// ------------------------------------------------------------
	// Start-up delay
	// ------------------------------------------------------------
	startup_delay #(
		.CYC0(STARTUP_CYC0),
		.CYC1(STARTUP_CYC1),
		.CYC2(STARTUP_CYC2),
		.CYC3(STARTUP_CYC3)
	) u_delay (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.load(load),
		.sel(clock_select_fuse),
		.done(delay_done)
	);

	// Load on the first quiet cycle after the last source falls
	assign load = (s_q.state == ST_HOLD) && !any_src; // see (R03) (R06) (R07) (R10)

	// ------------------------------------------------------------
	// Reset output
	// ------------------------------------------------------------
	// Asynchronous set so ports reset with no clock; release is on
	// the clock edge only, avoiding a metastable release.
	always_ff @(posedge core_clk or posedge any_src) begin
		if (any_src) begin
			reset_q <= 1'b1; // see (R02) (R22)
		end else begin
			reset_q <= (s_q.state != ST_RUN) || !reset_n; // see (R01) (R22)
		end
	end

	assign internal_reset = reset_q;

	// ------------------------------------------------------------
	// Sleep power gating
	// ------------------------------------------------------------
	// Both the I/O and converter clocks stop in these modes
	always_comb begin
		case (sleep_mode_t'(s_q.mode))
			MODE_DOWN, MODE_SAVE, MODE_STANDBY: deep_sleep = sleep_active;
			default: deep_sleep = 1'b0;
		endcase
	end

	// Comparator on the reference is never auto-disabled
	assign cmp_on = s_q.cmp_en && (!deep_sleep || s_q.cmp_ref); // see (R18)

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rdata = 8'h00;

		// Sequencer
		case (s_q.state)
			ST_HOLD: begin
				if (!any_src) begin
					s_d.state = ST_COUNT; // see (R03)
				end
			end
			ST_COUNT: begin
				if (any_src) begin
					s_d.state = ST_HOLD;
				end else if (delay_done) begin
					s_d.state = ST_RUN; // see (R06) (R08)
				end
			end
			ST_RUN: begin
				if (any_src) begin
					s_d.state = ST_HOLD; // see (R07) (R08)
				end
			end
			default: s_d.state = ST_HOLD;
		endcase

		// Register writes; a cause flag clears where its bit is written zero
		if (bus.wr) begin
			case (bus.addr)
				REG_CAUSE: s_d.flags = s_q.flags & bus.wdata[FLAG_W-1:0];
				REG_POWER: begin
					s_d.conv_en = bus.wdata[PWR_CONV_EN];
					s_d.cmp_en = bus.wdata[PWR_CMP_EN];
					s_d.cmp_ref = bus.wdata[PWR_CMP_REF];
					s_d.mode = bus.wdata[PWR_MODE_LO +: MODE_W];
				end
				default: s_d.flags = s_q.flags;
			endcase
		end

		// Internal reset restores the power register, but keeps the cause
		// flags so software can still see why it restarted
		if (reset_q) begin
			s_d.conv_en = POWER_RESET[PWR_CONV_EN]; // see (R01)
			s_d.cmp_en = POWER_RESET[PWR_CMP_EN];
			s_d.cmp_ref = POWER_RESET[PWR_CMP_REF];
			s_d.mode = POWER_RESET[PWR_MODE_LO +: MODE_W];
		end

		// Hardware sets win over a software clear in the same cycle
		if (src.power_on_detect) begin
			s_d.flags = '0; // see (R12) (R13) (R14)
			s_d.flags[FLAG_PWRON] = 1'b1; // see (R15)
		end else begin
			if (wdog_pulse) begin
				s_d.flags[FLAG_WDOG] = 1'b1; // see (R12)
			end
			if (bo_active) begin
				s_d.flags[FLAG_BROWN] = 1'b1; // see (R13)
			end
			if (pin_low) begin
				s_d.flags[FLAG_EXT] = 1'b1; // see (R14)
			end
		end

		// Register reads, data in the following cycle
		if (bus.rd) begin
			case (bus.addr)
				REG_CAUSE: s_d.rdata = {4'h0, s_q.flags}; // see (R11)
				REG_POWER: s_d.rdata = {1'b0, s_q.mode, 1'b0, s_q.cmp_ref, s_q.cmp_en,
					s_q.conv_en};
				REG_STATUS: s_d.rdata = {4'h0, bo_active, any_src, s_q.state};
				default: s_d.rdata = 8'h00;
			endcase
		end

		// Power gating outputs
		s_d.pwr.input_buffer_enable = !deep_sleep; // see (R17)
		s_d.pwr.wake_buffer_enable = 1'b1; // see (R17)
		s_d.pwr.comparator_power = cmp_on;
		s_d.pwr.wdog_run = src.wdog_enable; // see (R20)
		s_d.pwr.brownout_run = src.brownout_enable_fuse; // see (R20)
		s_d.pwr.converter_run = s_q.conv_en; // see (R21)
		s_d.pwr.reference_enable = src.brownout_enable_fuse
			|| (cmp_on && s_q.cmp_ref) || s_q.conv_en; // see (R19)
		if (s_q.conv_en && !s_q.pwr.converter_run) begin
			s_d.pwr.converter_extended = 1'b1; // see (R21)
		end else if (conversion_start) begin
			s_d.pwr.converter_extended = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// The block reset keeps cause flags, so software can read them
	// after the core was restarted by this very sequencer.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_q.state <= ST_HOLD;
			s_q.flags <= s_d.flags;
			s_q.conv_en <= POWER_RESET[PWR_CONV_EN];
			s_q.cmp_en <= POWER_RESET[PWR_CMP_EN];
			s_q.cmp_ref <= POWER_RESET[PWR_CMP_REF];
			s_q.mode <= POWER_RESET[PWR_MODE_LO +: MODE_W];
			s_q.rdata <= 8'h00;
			s_q.pwr <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign pwr = s_q.pwr;

endmodule

// ---- core/reset_seq_pkg.sv ----
package reset_seq_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned BROWNOUT_MIN_NS = 2000;
	localparam int unsigned BROWNOUT_MIN_CYC =
		(BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned STARTUP_SEL_W = 2;
	localparam int unsigned STARTUP_SEL_N = 4;
	// Start-up delay per fuse setting, in microseconds
	localparam int unsigned STARTUP_TIME_US [STARTUP_SEL_N] = '{1, 4100, 65000, 65000};
	localparam int unsigned STARTUP_DEF_CYC [STARTUP_SEL_N] = '{
		(STARTUP_TIME_US[0] * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
		(STARTUP_TIME_US[1] * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
		(STARTUP_TIME_US[2] * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
		(STARTUP_TIME_US[3] * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS};
	localparam int unsigned DELAY_W = 22;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 2;
	localparam logic [ADDR_W-1:0] REG_CAUSE = 2'h0;
	localparam logic [ADDR_W-1:0] REG_POWER = 2'h1;
	localparam logic [ADDR_W-1:0] REG_STATUS = 2'h2;

	localparam int unsigned FLAG_PWRON = 0;
	localparam int unsigned FLAG_EXT = 1;
	localparam int unsigned FLAG_BROWN = 2;
	localparam int unsigned FLAG_WDOG = 3;
	localparam int unsigned FLAG_W = 4;

	localparam int unsigned PWR_CONV_EN = 0;
	localparam int unsigned PWR_CMP_EN = 1;
	localparam int unsigned PWR_CMP_REF = 2;
	localparam int unsigned PWR_MODE_LO = 4;
	localparam int unsigned MODE_W = 3;

	localparam logic [FLAG_W-1:0] FLAGS_RESET = 4'h0;
	localparam logic [7:0] POWER_RESET = 8'h00;

	// ------------------------------------------------------------
	// Sleep modes
	// ------------------------------------------------------------
	typedef enum logic [MODE_W-1:0] {
		MODE_IDLE = 3'h0,
		MODE_NOISE = 3'h1,
		MODE_DOWN = 3'h2,
		MODE_SAVE = 3'h3,
		MODE_STANDBY = 3'h6
	} sleep_mode_t;

	// ------------------------------------------------------------
	// Sequencer states, Gray along hold, count, run
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_HOLD = 2'h0,
		ST_COUNT = 2'h1,
		ST_RUN = 2'h3
	} seq_state_t;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic power_on_detect;
		logic reset_pin_n;
		logic wdog_timeout;
		logic wdog_enable;
		logic supply_below_bot;
		logic brownout_enable_fuse;
	} reset_src_t;

	typedef struct packed {
		logic input_buffer_enable;
		logic wake_buffer_enable;
		logic comparator_power;
		logic reference_enable;
		logic wdog_run;
		logic brownout_run;
		logic converter_run;
		logic converter_extended;
	} power_out_t;

endpackage

// ---- core/brownout_filter.sv ----
`timescale 1ns/1ns
module brownout_filter
	import reset_seq_pkg::*;
#(
	parameter int unsigned MIN_CYC = BROWNOUT_MIN_CYC
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic below,
	output logic bo_active
);
	import reset_seq_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
		logic active;
	} filt_t;

	filt_t s_q, s_d;

	// ------------------------------------------------------------
	// Dip filter
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		if (!enable || !below) begin
			s_d.cnt = 8'h00;
			s_d.active = 1'b0;
		end else if (s_q.cnt >= 8'(MIN_CYC - 1)) begin
			s_d.active = 1'b1; // see (R09)
		end else begin
			s_d.cnt = s_q.cnt + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bo_active = s_q.active;

endmodule

// ---- core/startup_delay.sv ----
`timescale 1ns/1ns
module startup_delay
	import reset_seq_pkg::*;
#(
	parameter int unsigned CYC0 = STARTUP_DEF_CYC[0],
	parameter int unsigned CYC1 = STARTUP_DEF_CYC[1],
	parameter int unsigned CYC2 = STARTUP_DEF_CYC[2],
	parameter int unsigned CYC3 = STARTUP_DEF_CYC[3]
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [STARTUP_SEL_W-1:0] sel,
	output logic done
);
	import reset_seq_pkg::*;

	typedef struct packed {
		logic [DELAY_W-1:0] cnt;
		logic busy;
		logic done;
	} dly_t;

	dly_t s_q, s_d;
	logic [DELAY_W-1:0] period;

	// ------------------------------------------------------------
	// Period select
	// ------------------------------------------------------------
	always_comb begin
		case (sel)
			2'h0: period = DELAY_W'(CYC0);
			2'h1: period = DELAY_W'(CYC1);
			2'h2: period = DELAY_W'(CYC2);
			default: period = DELAY_W'(CYC3);
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (load) begin
			s_d.cnt = period; // see (R03)
			s_d.busy = 1'b1;
		end else if (s_q.busy) begin
			if (s_q.cnt <= DELAY_W'(1)) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - DELAY_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done = s_q.done;

endmodule

// ---- verification/reset_seq_asserts.sv ----
`timescale 1ns/1ns
module reset_seq_asserts #(
	parameter int unsigned STARTUP_CYC0 = 5,
	parameter int unsigned STARTUP_CYC1 = 5,
	parameter int unsigned STARTUP_CYC2 = 5,
	parameter int unsigned STARTUP_CYC3 = 5,
	parameter int unsigned BO_MIN_CYC = 3
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire reset_seq_pkg::reset_src_t src,
	input wire logic [reset_seq_pkg::STARTUP_SEL_W-1:0] clock_select_fuse,
	input wire logic sleep_active,
	input wire logic conversion_start,
	input wire reset_seq_pkg::bus_req_t bus,
	input wire logic [7:0] rdata,
	input wire logic internal_reset,
	input wire reset_seq_pkg::power_out_t pwr
);
	import reset_seq_pkg::*;
	default clocking dck @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// ----
	// Helper counters, small delays only
	// ----
	logic hit;
	logic [7:0] lim;
	logic [7:0] quiet_q;
	logic [7:0] low_q;
	assign hit = src.power_on_detect || !src.reset_pin_n || (src.wdog_timeout && src.wdog_enable);
	always_comb begin
		case (clock_select_fuse)
			2'h0: lim = 8'(STARTUP_CYC0);
			2'h1: lim = 8'(STARTUP_CYC1);
			2'h2: lim = 8'(STARTUP_CYC2);
			default: lim = 8'(STARTUP_CYC3);
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (!reset_n || hit) begin
			quiet_q <= 8'h00;
		end else if (quiet_q != 8'hFF) begin
			quiet_q <= quiet_q + 8'h01;
		end
		if (!reset_n || !(src.supply_below_bot && src.brownout_enable_fuse)) begin
			low_q <= 8'h00;
		end else if (low_q != 8'hFF) begin
			low_q <= low_q + 8'h01;
		end
	end
	property p_async;
		!src.reset_pin_n || src.power_on_detect |-> internal_reset;
	endproperty
	a_async: assert property (p_async) else $error("source did not set reset");
	property p_wdog;
		src.wdog_timeout && src.wdog_enable |-> internal_reset;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog did not set reset");
	property p_stretch;
		quiet_q <= lim + 8'h02 |-> internal_reset;
	endproperty
	a_stretch: assert property (p_stretch) else $error("reset released early");
	property p_bofilt;
		$rose(internal_reset) && !hit |-> low_q >= 8'(BO_MIN_CYC);
	endproperty
	a_bofilt: assert property (p_bofilt) else $error("short dip caused reset");
	property p_rsvd;
		bus.rd && bus.addr == REG_CAUSE |=> rdata[7:4] == 4'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
	property p_wdrun;
		$stable(src.wdog_enable) && $past(reset_n) |-> pwr.wdog_run == src.wdog_enable;
	endproperty
	a_wdrun: assert property (p_wdrun) else $error("watchdog run wrong");
	property p_ref;
		src.brownout_enable_fuse ##1 src.brownout_enable_fuse |-> pwr.reference_enable;
	endproperty
	a_ref: assert property (p_ref) else $error("reference off with detector");
	property p_conv;
		sleep_active && pwr.converter_run && !$past(bus.wr) && !$past(internal_reset)
			|=> pwr.converter_run;
	endproperty
	a_conv: assert property (p_conv) else $error("converter changed on sleep");
	property p_buf;
		$past(reset_n) && !sleep_active ##1 !sleep_active |-> pwr.input_buffer_enable;
	endproperty
	a_buf: assert property (p_buf) else $error("buffers off while awake");
	c_rel: cover property ($fell(internal_reset));
	c_wd: cover property (src.wdog_timeout && src.wdog_enable);
	c_bo: cover property ($rose(internal_reset) && !hit);
endmodule
bind reset_source_sequencer reset_seq_asserts #(
	.STARTUP_CYC0(STARTUP_CYC0), .STARTUP_CYC1(STARTUP_CYC1),
	.STARTUP_CYC2(STARTUP_CYC2), .STARTUP_CYC3(STARTUP_CYC3), .BO_MIN_CYC(BO_MIN_CYC)
) chk_u (
	.core_clk(core_clk), .reset_n(reset_n), .src(src), .clock_select_fuse(clock_select_fuse),
	.sleep_active(sleep_active), .conversion_start(conversion_start), .bus(bus),
	.rdata(rdata), .internal_reset(internal_reset), .pwr(pwr)
);

// ---- verification/reset_partner.sv ----
`timescale 1ns/1ns
module reset_partner (
	input wire logic core_clk,
	output reset_seq_pkg::reset_src_t src
);
	import reset_seq_pkg::*;
	// ----
	// Supply, pin and watchdog sources
	// ----
	reset_src_t base;
	initial begin
		base = '{reset_pin_n: 1'b1, default: 1'b0};
		src = '{power_on_detect: 1'b1, reset_pin_n: 1'b1, default: 1'b0};
	end
	// Enables change only between events
	task automatic setb(input reset_src_t b);
		@(posedge core_clk);
		base = b;
		src <= b;
	endtask
	// Caller sets pin low past minimum width, watchdog one cycle
	task automatic drive(input reset_src_t act, input int c);
		@(posedge core_clk);
		src <= act;
		repeat (c) @(posedge core_clk);
		src <= base;
	endtask
endmodule

// ---- verification/tb_reset_source_sequencer.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("wrong value at %0t: got %0h expected %0h", $time, g, e); \
	end \
end
module tb_reset_source_sequencer;
	import reset_seq_pkg::*;
	localparam int unsigned NS [4] = '{4, 6, 8, 5};
	localparam int unsigned BO = 3;
	logic core_clk;
	logic reset_n;
	logic [1:0] fuse;
	logic sleep_active;
	logic conv_go;
	bus_req_t bus;
	logic [7:0] rdata;
	logic internal_reset;
	power_out_t pwr;
	reset_src_t src;
	reset_src_t s;
	logic [7:0] d;
	int n;
	int bad_count;
	int total_checks;
	reset_partner pu (.core_clk(core_clk), .src(src));
	reset_source_sequencer #(.STARTUP_CYC0(NS[0]), .STARTUP_CYC1(NS[1]),
		.STARTUP_CYC2(NS[2]), .STARTUP_CYC3(NS[3]), .BO_MIN_CYC(BO)) dut_u (
		.core_clk(core_clk), .reset_n(reset_n), .src(src), .clock_select_fuse(fuse),
		.sleep_active(sleep_active), .conversion_start(conv_go), .bus(bus),
		.rdata(rdata), .internal_reset(internal_reset), .pwr(pwr));
	// ----
	// Shared tasks
	// ----
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic pulse(input int f, input int c);
		s = pu.base;
		case (f)
			0: s.power_on_detect = 1'b1;
			1: s.reset_pin_n = 1'b0;
			2: s.wdog_timeout = 1'b1;
			default: s.supply_below_bot = 1'b1;
		endcase
		pu.drive(s, c);
	endtask
	// Edges from last source cycle until reset is seen low
	task automatic rel();
		n = 0;
		do begin
			@(posedge core_clk);
			#1 n++;
		end while (internal_reset !== 1'b0 && n < 300);
		if (n >= 300) begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_por();
		pulse(0, 2);
		rel();
		`CHK(n, NS[0] + 3)
		rd(REG_CAUSE);
		`CHK(d, 8'h01)
		wr(REG_CAUSE, 8'hF0);
		rd(REG_CAUSE);
		`CHK(d, 8'h00)
		wr(2'h3, 8'hFF);
		rd(2'h3);
		`CHK(d, 8'h00)
		rd(REG_STATUS);
		`CHK(d, {6'h00, ST_RUN})
		$display("power-on test done");
	endtask
	task automatic t_pin();
		for (int i = 0; i < 4; i++) begin
			wr(REG_POWER, 8'h01);
			fuse <= 2'(i);
			pulse(1, 40);
			rel();
			`CHK(n, NS[i] + 3)
			rd(REG_POWER);
			`CHK(d, 8'h00)
			rd(REG_CAUSE);
			`CHK(d, 8'h02)
			wr(REG_CAUSE, 8'h00);
		end
		$display("pin test done");
	endtask
	task automatic t_wd();
		s = pu.base;
		s.wdog_enable = 1'b1;
		pu.setb(s);
		pulse(2, 1);
		rel();
		`CHK(n, NS[3] + 3)
		`CHK(pwr.wdog_run, 1'b1)
		rd(REG_CAUSE);
		`CHK(d, 8'h08)
		wr(REG_CAUSE, 8'h00);
		s = pu.base;
		s.wdog_enable = 1'b0;
		pu.setb(s);
		pulse(2, 1);
		repeat (3) @(posedge core_clk);
		#1 `CHK(internal_reset, 1'b0)
		rd(REG_CAUSE);
		`CHK(d, 8'h00)
		$display("watchdog test done");
	endtask
	task automatic t_bo();
		s = pu.base;
		s.brownout_enable_fuse = 1'b1;
		pu.setb(s);
		pulse(3, BO - 1);
		repeat (3) @(posedge core_clk);
		#1 `CHK(internal_reset, 1'b0)
		`CHK(pwr.reference_enable, 1'b1)
		`CHK(pwr.brownout_run, 1'b1)
		pulse(3, BO + 4);
		rel();
		// One more edge than a pin reset: the dip filter output is registered
		`CHK(n, NS[3] + 4)
		rd(REG_CAUSE);
		`CHK(d, 8'h04)
		pulse(1, 40);
		rel();
		rd(REG_CAUSE);
		`CHK(d, 8'h06)
		pulse(0, 2);
		rel();
		rd(REG_CAUSE);
		`CHK(d, 8'h01)
		wr(REG_CAUSE, 8'h00);
		s = pu.base;
		s.brownout_enable_fuse = 1'b0;
		pu.setb(s);
		$display("brown-out test done");
	endtask
	task automatic t_pwr();
		logic [2:0] md [5];
		logic deep;
		md = '{MODE_IDLE, MODE_NOISE, MODE_DOWN, MODE_SAVE, MODE_STANDBY};
		for (int i = 0; i < 5; i++) begin
			deep = i > 1;
			wr(REG_POWER, {1'b0, md[i], 4'h2});
			sleep_active <= 1'b1;
			repeat (3) @(posedge core_clk);
			#1 `CHK(pwr.comparator_power, !deep)
			`CHK(pwr.input_buffer_enable, !deep)
			`CHK(pwr.wake_buffer_enable, 1'b1)
			`CHK(pwr.reference_enable, 1'b0)
			sleep_active <= 1'b0;
		end
		wr(REG_POWER, 8'h26);
		sleep_active <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1 `CHK(pwr.reference_enable, 1'b1)
		wr(REG_POWER, 8'h21);
		repeat (3) @(posedge core_clk);
		#1 `CHK(pwr.converter_run, 1'b1)
		sleep_active <= 1'b0;
		wr(REG_POWER, 8'h00);
		wr(REG_POWER, 8'h01);
		repeat (2) @(posedge core_clk);
		#1 `CHK(pwr.converter_extended, 1'b1)
		conv_go <= 1'b1;
		@(posedge core_clk);
		conv_go <= 1'b0;
		@(posedge core_clk);
		#1 `CHK(pwr.converter_extended, 1'b0)
		$display("power test done");
	endtask
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		reset_n = 1'b0;
		fuse = 2'h0;
		sleep_active = 1'b0;
		conv_go = 1'b0;
		bus = '0;
		bad_count = 0;
		total_checks = 0;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		t_por();
		t_pin();
		t_wd();
		t_bo();
		t_pwr();
		tally_and_finish();
	end
endmodule
